// ---- rtl/pcg_top.sv ----
// register bank for protector comparators and pin configuration
// assumes a one-cycle register port on clock_i; pins are asynchronous
`timescale 1ns/1ps
module pcg_top (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] pin_in_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_cs_i,
  input wire logic mb_drive_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_n_o,
  output logic [7:0] pin_adc_en_o,
  output logic [7:0] pin_temp_en_o,
  output logic [7:0] pin_pull_up_o,
  output logic [7:0] pin_pull_dn_o,
  output logic [7:0] pin_din_o,
  output logic spi_miso_o,
  output logic fault_out_pin_o,
  output logic [1:0] voltage_cmp_mode_o,
  output logic [3:0] vcmp_seq_state_o,
  output logic [3:0] voltage_cmp_cell_o,
  output logic [15:0] uv_cell_enable_o,
  output logic [12:0] overvoltage_level_o,
  output logic [12:0] undervoltage_level_o,
  output logic uv_lock_threshold_select_o,
  output logic voltage_cmp_start_o,
  output logic [1:0] temp_cmp_mode_o,
  output logic [2:0] temp_cmp_channel_o,
  output logic [6:0] overtemp_level_o,
  output logic [2:0] undertemp_level_o,
  output logic ot_lock_threshold_select_o,
  output logic temp_cmp_start_o
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] overvoltage_threshold_r;
  logic [7:0] undervoltage_threshold_r;
  logic [7:0] temp_thresh_r;
  logic [7:0] uv_excl_upper_r;
  logic [7:0] uv_excl_lower_r;
  logic [7:0] pin_cfg_a_r;
  logic [7:0] pin_cfg_b_r;
  logic [7:0] pin_cfg_c_r;
  logic [7:0] pin_cfg_d_r;
  logic [7:0] vcmp_ctrl_r;
  logic [7:0] tcmp_ctrl_r;
  logic [4:0] module_balance_timer_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic wr_ov;
  logic wr_uv;
  logic wr_temp;
  logic wr_vctrl;
  logic wr_tctrl;
  logic voltage_cmp_go;
  logic temp_cmp_go;
  logic [23:0] pin_funcs;
  logic [7:0] pin_override;
  logic [7:0] ovr_out;
  logic [7:0] ovr_oe_n;
  pcg_pkg::pcg_seq_t vseq_r;

  // address match shared by every write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction : hit

  // decoded write strobes
  assign wr_ov = reg_wr_i && hit(reg_addr_i, pcg_pkg::ADDR_OVERVOLTAGE_THRESHOLD);
  assign wr_uv = reg_wr_i && hit(reg_addr_i, pcg_pkg::ADDR_UNDERVOLTAGE_THRESHOLD);
  assign wr_temp = reg_wr_i && hit(reg_addr_i, pcg_pkg::ADDR_TEMP_THRESH);
  assign wr_vctrl = reg_wr_i && hit(reg_addr_i, pcg_pkg::ADDR_VCMP_CTRL);
  assign wr_tctrl = reg_wr_i && hit(reg_addr_i, pcg_pkg::ADDR_TCMP_CTRL);
  assign voltage_cmp_go = wr_vctrl && reg_wdata_i[pcg_pkg::VC_GO_BIT];
  assign temp_cmp_go = wr_tctrl && reg_wdata_i[pcg_pkg::TC_GO_BIT];

  // ---------------------------------------------------------------
  // threshold registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      overvoltage_threshold_r <= pcg_pkg::RST_OVERVOLTAGE_THRESHOLD;
      undervoltage_threshold_r <= pcg_pkg::RST_ZERO;
      temp_thresh_r <= pcg_pkg::RST_TEMP_THRESH;
      uv_excl_upper_r <= pcg_pkg::RST_ZERO;
      uv_excl_lower_r <= pcg_pkg::RST_ZERO;
    end
    else if (reg_wr_i)
    begin
      if (wr_ov)
        overvoltage_threshold_r <= reg_wdata_i;
      if (wr_uv)
        undervoltage_threshold_r <= reg_wdata_i;
      if (wr_temp)
        temp_thresh_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_UV_EXCL_UPPER))
        uv_excl_upper_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_UV_EXCL_LOWER))
        uv_excl_lower_r <= reg_wdata_i;
    end
  end

  // pin configuration and balance timer registers
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pin_cfg_a_r <= pcg_pkg::RST_ZERO;
      pin_cfg_b_r <= pcg_pkg::RST_ZERO;
      pin_cfg_c_r <= pcg_pkg::RST_ZERO;
      pin_cfg_d_r <= pcg_pkg::RST_ZERO;
      module_balance_timer_r <= 5'h00;
    end
    else if (reg_wr_i)
    begin
      if (hit(reg_addr_i, pcg_pkg::ADDR_PIN_CFG_A))
        pin_cfg_a_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_PIN_CFG_B))
        pin_cfg_b_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_PIN_CFG_C))
        pin_cfg_c_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_PIN_CFG_D))
        pin_cfg_d_r <= reg_wdata_i;
      if (hit(reg_addr_i, pcg_pkg::ADDR_MB_TIMER))
        module_balance_timer_r <= reg_wdata_i[pcg_pkg::MB_TIMER_W-1:0];
    end
  end

  // control registers; go bits never stored so they read as ready
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      vcmp_ctrl_r <= pcg_pkg::RST_ZERO;
      tcmp_ctrl_r <= pcg_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_vctrl)
        vcmp_ctrl_r <= reg_wdata_i & ~(8'h01 << pcg_pkg::VC_GO_BIT);
      if (wr_tctrl)
        tcmp_ctrl_r <= reg_wdata_i & ~((8'h01 << pcg_pkg::TC_GO_BIT) | (8'h01 << pcg_pkg::TC_RSVD_BIT));
    end
  end

  // ---------------------------------------------------------------
  // voltage comparator shadow, loaded only by go
  // ---------------------------------------------------------------
  // shadow copies; old settings held until go
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      voltage_cmp_mode_o <= pcg_pkg::MODE_IDLE;
      voltage_cmp_cell_o <= 4'h0;
      overvoltage_level_o <= pcg_pkg::OV_BASE_LO_MV;
      undervoltage_level_o <= pcg_pkg::UV_BASE_MV;
      uv_cell_enable_o <= 16'hffff;
      uv_lock_threshold_select_o <= 1'b0;
      voltage_cmp_start_o <= 1'b0;
    end
    else
    begin
      voltage_cmp_start_o <= voltage_cmp_go;
      if (voltage_cmp_go)
      begin
        voltage_cmp_mode_o <= reg_wdata_i[pcg_pkg::VC_MODE_LSB +: 2];
        voltage_cmp_cell_o <= reg_wdata_i[pcg_pkg::VC_CELL_LSB +: 4];
        overvoltage_level_o <= ov_decode(overvoltage_threshold_r[5:0]);
        undervoltage_level_o <= uv_decode(undervoltage_threshold_r[5:0]);
        uv_cell_enable_o <= ~{uv_excl_upper_r, uv_excl_lower_r};
        uv_lock_threshold_select_o <= (reg_wdata_i[pcg_pkg::VC_MODE_LSB +: 2] == pcg_pkg::MODE_LOCK) &&
                                      reg_wdata_i[pcg_pkg::VC_THR_SEL_BIT];
      end
    end
  end

  // overvoltage code to millivolts
  function automatic logic [12:0] ov_decode(input logic [5:0] code);
    logic [12:0] off;
    off = 13'(code[3:0]) * pcg_pkg::OV_STEP_MV;
    ov_decode = pcg_pkg::OV_BASE_LO_MV;
    if (code >= pcg_pkg::OV_WIN_LO_MIN && code <= pcg_pkg::OV_WIN_LO_MAX)
      ov_decode = pcg_pkg::OV_BASE_LO_MV + off - 13'(2) * pcg_pkg::OV_STEP_MV;
    else if (code >= pcg_pkg::OV_WIN_MID_MIN && code <= pcg_pkg::OV_WIN_MID_MAX)
      ov_decode = pcg_pkg::OV_BASE_MID_MV + off - 13'(2) * pcg_pkg::OV_STEP_MV;
    else if (code >= pcg_pkg::OV_WIN_HI_MIN && code <= pcg_pkg::OV_WIN_HI_MAX)
      ov_decode = pcg_pkg::OV_BASE_HI_MV + off - 13'(2) * pcg_pkg::OV_STEP_MV;
  endfunction : ov_decode

  // undervoltage code to millivolts, saturating at top of range
  function automatic logic [12:0] uv_decode(input logic [5:0] code);
    logic [12:0] mv;
    mv = pcg_pkg::UV_BASE_MV + 13'(code) * pcg_pkg::UV_STEP_MV;
    uv_decode = (mv > pcg_pkg::UV_MAX_MV) ? pcg_pkg::UV_MAX_MV : mv;
  endfunction : uv_decode

  // voltage sequencer state follows the sampled mode
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      vseq_r <= pcg_pkg::SEQ_IDLE;
    else if (voltage_cmp_go)
    begin
      unique case (reg_wdata_i[pcg_pkg::VC_MODE_LSB +: 2])
        pcg_pkg::MODE_IDLE: vseq_r <= pcg_pkg::SEQ_IDLE;
        pcg_pkg::MODE_ROUND: vseq_r <= pcg_pkg::SEQ_ROUND;
        pcg_pkg::MODE_SELFTEST: vseq_r <= pcg_pkg::SEQ_SELFTEST;
        pcg_pkg::MODE_LOCK: vseq_r <= pcg_pkg::SEQ_LOCK;
      endcase
    end
  end
  assign vcmp_seq_state_o = vseq_r;

  // ---------------------------------------------------------------
  // temperature comparator shadow, loaded only by go
  // ---------------------------------------------------------------
  // old settings held; mode sampled
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      temp_cmp_mode_o <= pcg_pkg::MODE_IDLE;
      temp_cmp_channel_o <= 3'h0;
      overtemp_level_o <= pcg_pkg::OT_MAX_PCT;
      undertemp_level_o <= 3'h7;
      ot_lock_threshold_select_o <= 1'b0;
      temp_cmp_start_o <= 1'b0;
    end
    else
    begin
      temp_cmp_start_o <= temp_cmp_go;
      if (temp_cmp_go)
      begin
        temp_cmp_mode_o <= reg_wdata_i[pcg_pkg::TC_MODE_LSB +: 2];
        temp_cmp_channel_o <= reg_wdata_i[pcg_pkg::TC_CHAN_LSB +: 3];
        overtemp_level_o <= ot_decode(temp_thresh_r[pcg_pkg::OT_FIELD_LSB +: 5]);
        undertemp_level_o <= temp_thresh_r[pcg_pkg::UT_FIELD_LSB +: 3];
        ot_lock_threshold_select_o <= (reg_wdata_i[pcg_pkg::TC_MODE_LSB +: 2] == pcg_pkg::MODE_LOCK) &&
                                      reg_wdata_i[pcg_pkg::TC_THR_SEL_BIT];
      end
    end
  end

  // overtemperature code to percent; unused codes fall to the cap
  function automatic logic [6:0] ot_decode(input logic [4:0] code);
    logic [6:0] pct;
    pct = pcg_pkg::OT_BASE_PCT + 7'(code) * pcg_pkg::OT_STEP_PCT;
    ot_decode = (pct > pcg_pkg::OT_MAX_PCT) ? pcg_pkg::OT_MAX_PCT : pct;
  endfunction : ot_decode

  // ---------------------------------------------------------------
  // pin synchronisers and overrides
  // ---------------------------------------------------------------
  // two stages before any logic reads a pin
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end
    else
    begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pin_funcs = {pin_cfg_d_r[5:0], pin_cfg_c_r[5:0], pin_cfg_b_r[5:0], pin_cfg_a_r[5:0]};

  // override ownership per pin, index 0 is pin 1
  always_comb
  begin
    pin_override = 8'h00;
    ovr_out = 8'h00;
    ovr_oe_n = 8'hff;
    if (module_balance_timer_r != 5'h00)
    begin
      pin_override[2] = 1'b1;
      ovr_out[2] = mb_drive_i;
      ovr_oe_n[2] = 1'b0;
    end
    // pins 4 to 7 to SPI
    if (pin_cfg_a_r[pcg_pkg::SPI_EN_BIT])
    begin
      pin_override[6:3] = 4'hf;
      ovr_out[3] = spi_cs_i;
      ovr_oe_n[3] = 1'b0;
      ovr_out[5] = spi_mosi_i;
      ovr_oe_n[5] = 1'b0;
      // pin 7 clock, pin 5 input
      ovr_out[6] = spi_sclk_i;
      ovr_oe_n[6] = 1'b0;
    end
    if (pin_cfg_a_r[pcg_pkg::FAULT_IN_EN_BIT])
      pin_override[7] = 1'b1;
  end

  // fault pin and SPI data input
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      fault_out_pin_o <= 1'b1;
      spi_miso_o <= 1'b0;
    end
    else
    begin
      fault_out_pin_o <= pin_cfg_a_r[pcg_pkg::FAULT_IN_EN_BIT] ? pin_sync_r[7] : 1'b1;
      spi_miso_o <= pin_cfg_a_r[pcg_pkg::SPI_EN_BIT] ? pin_sync_r[4] : 1'b0;
    end
  end

  // one decoder per pin
  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::NUM_PINS; gi++)
    begin : g_pin
      pcg_pin_mux u_mux (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .func_i(pin_funcs[gi*3 +: 3]),
        .override_i(pin_override[gi]),
        .ovr_out_i(ovr_out[gi]),
        .ovr_oe_n_i(ovr_oe_n[gi]),
        .pin_sync_i(pin_sync_r[gi]),
        .pin_out_o(pin_out_o[gi]),
        .pin_oe_n_o(pin_oe_n_o[gi]),
        .adc_en_o(pin_adc_en_o[gi]),
        .temp_en_o(pin_temp_en_o[gi]),
        .pull_up_o(pin_pull_up_o[gi]),
        .pull_dn_o(pin_pull_dn_o[gi]),
        .din_o(pin_din_o[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        pcg_pkg::ADDR_OVERVOLTAGE_THRESHOLD: reg_rdata_o <= overvoltage_threshold_r;
        pcg_pkg::ADDR_UNDERVOLTAGE_THRESHOLD: reg_rdata_o <= undervoltage_threshold_r;
        pcg_pkg::ADDR_TEMP_THRESH: reg_rdata_o <= temp_thresh_r;
        pcg_pkg::ADDR_UV_EXCL_UPPER: reg_rdata_o <= uv_excl_upper_r;
        pcg_pkg::ADDR_UV_EXCL_LOWER: reg_rdata_o <= uv_excl_lower_r;
        pcg_pkg::ADDR_PIN_CFG_A: reg_rdata_o <= pin_cfg_a_r;
        pcg_pkg::ADDR_PIN_CFG_B: reg_rdata_o <= pin_cfg_b_r;
        pcg_pkg::ADDR_PIN_CFG_C: reg_rdata_o <= pin_cfg_c_r;
        pcg_pkg::ADDR_PIN_CFG_D: reg_rdata_o <= pin_cfg_d_r;
        pcg_pkg::ADDR_VCMP_CTRL: reg_rdata_o <= vcmp_ctrl_r;
        pcg_pkg::ADDR_TCMP_CTRL: reg_rdata_o <= tcmp_ctrl_r;
        pcg_pkg::ADDR_MB_TIMER: reg_rdata_o <= {3'h0, module_balance_timer_r};
        pcg_pkg::ADDR_CMP_STATUS: reg_rdata_o <= {temp_cmp_mode_o, 2'h0, vseq_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : pcg_top

// ---- rtl/pcg_pkg.sv ----
// constants for the protector comparator and pin configuration block
// assumes a single 125 MHz clock domain and a plain register port
package pcg_pkg;
  // ---------------------------------------------------------------
  // register indices (byte offsets on the port)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_OVERVOLTAGE_THRESHOLD = 12'h009;
  localparam logic [11:0] ADDR_UNDERVOLTAGE_THRESHOLD = 12'h00a;
  localparam logic [11:0] ADDR_TEMP_THRESH = 12'h00b;
  localparam logic [11:0] ADDR_UV_EXCL_UPPER = 12'h00c;
  localparam logic [11:0] ADDR_UV_EXCL_LOWER = 12'h00d;
  localparam logic [11:0] ADDR_PIN_CFG_A = 12'h00e;
  localparam logic [11:0] ADDR_PIN_CFG_B = 12'h00f;
  localparam logic [11:0] ADDR_PIN_CFG_C = 12'h010;
  localparam logic [11:0] ADDR_PIN_CFG_D = 12'h011;
  localparam logic [11:0] ADDR_VCMP_CTRL = 12'h32c;
  localparam logic [11:0] ADDR_TCMP_CTRL = 12'h32d;
  localparam logic [11:0] ADDR_MB_TIMER = 12'h329;
  localparam logic [11:0] ADDR_CMP_STATUS = 12'h3f0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_OVERVOLTAGE_THRESHOLD = 8'h3f;
  localparam logic [7:0] RST_TEMP_THRESH = 8'he0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int VC_MODE_LSB = 0;
  localparam int VC_GO_BIT = 2;
  localparam int VC_CELL_LSB = 3;
  localparam int VC_THR_SEL_BIT = 7;
  localparam int TC_MODE_LSB = 0;
  localparam int TC_GO_BIT = 2;
  localparam int TC_CHAN_LSB = 3;
  localparam int TC_THR_SEL_BIT = 6;
  localparam int TC_RSVD_BIT = 7;
  localparam int FAULT_IN_EN_BIT = 7;
  localparam int SPI_EN_BIT = 6;
  localparam int OT_FIELD_LSB = 0;
  localparam int UT_FIELD_LSB = 5;
  localparam int MB_TIMER_W = 5;
  // ---------------------------------------------------------------
  // threshold decode constants (mV and percent)
  // ---------------------------------------------------------------
  localparam logic [12:0] OV_BASE_LO_MV = 13'd2700;
  localparam logic [12:0] OV_BASE_MID_MV = 13'd3500;
  localparam logic [12:0] OV_BASE_HI_MV = 13'd4175;
  localparam logic [12:0] OV_STEP_MV = 13'd25;
  localparam logic [5:0] OV_WIN_LO_MIN = 6'h02;
  localparam logic [5:0] OV_WIN_LO_MAX = 6'h0e;
  localparam logic [5:0] OV_WIN_MID_MIN = 6'h12;
  localparam logic [5:0] OV_WIN_MID_MAX = 6'h1e;
  localparam logic [5:0] OV_WIN_HI_MIN = 6'h22;
  localparam logic [5:0] OV_WIN_HI_MAX = 6'h2e;
  localparam logic [12:0] UV_BASE_MV = 13'd1200;
  localparam logic [12:0] UV_STEP_MV = 13'd50;
  localparam logic [12:0] UV_MAX_MV = 13'd3100;
  localparam logic [6:0] OT_BASE_PCT = 7'd10;
  localparam logic [6:0] OT_STEP_PCT = 7'd1;
  localparam logic [6:0] OT_MAX_PCT = 7'd39;
  // ---------------------------------------------------------------
  // modes and pin functions
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ROUND = 2'h1;
  localparam logic [1:0] MODE_SELFTEST = 2'h2;
  localparam logic [1:0] MODE_LOCK = 2'h3;
  localparam logic [2:0] PIN_HIGHZ = 3'h0;
  localparam logic [2:0] PIN_ADC_TEMP = 3'h1;
  localparam logic [2:0] PIN_ADC = 3'h2;
  localparam logic [2:0] PIN_DIG_IN = 3'h3;
  localparam logic [2:0] PIN_OUT_HIGH = 3'h4;
  localparam logic [2:0] PIN_OUT_LOW = 3'h5;
  localparam logic [2:0] PIN_ADC_PU = 3'h6;
  localparam logic [2:0] PIN_ADC_PD = 3'h7;
  localparam int NUM_PINS = 8;
  localparam int NUM_CELLS = 16;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_ROUND = 4'b0010,
    SEQ_SELFTEST = 4'b0100,
    SEQ_LOCK = 4'b1000
  } pcg_seq_t;
endpackage : pcg_pkg

// ---- rtl/pcg_pin_mux.sv ----
// one pin of the eight: decodes its function field and overrides
// assumes override flags are already resolved by the caller
`timescale 1ns/1ps
module pcg_pin_mux (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [2:0] func_i,
  input wire logic override_i,
  input wire logic ovr_out_i,
  input wire logic ovr_oe_n_i,
  input wire logic pin_sync_i,
  output logic pin_out_o,
  output logic pin_oe_n_o,
  output logic adc_en_o,
  output logic temp_en_o,
  output logic pull_up_o,
  output logic pull_dn_o,
  output logic din_o
);
  // ---------------------------------------------------------------
  // registered function decode
  // ---------------------------------------------------------------
  // pin function decode
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pin_out_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
      adc_en_o <= 1'b0;
      temp_en_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_dn_o <= 1'b0;
      din_o <= 1'b0;
    end
    else if (override_i)
    begin
      // override owner sets pin output and output enable; analog paths are cut
      pin_out_o <= ovr_out_i;
      pin_oe_n_o <= ovr_oe_n_i;
      adc_en_o <= 1'b0;
      temp_en_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_dn_o <= 1'b0;
      din_o <= pin_sync_i;
    end
    else
    begin
      pin_out_o <= (func_i == pcg_pkg::PIN_OUT_HIGH);
      pin_oe_n_o <= !((func_i == pcg_pkg::PIN_OUT_HIGH) || (func_i == pcg_pkg::PIN_OUT_LOW));
      adc_en_o <= (func_i == pcg_pkg::PIN_ADC_TEMP) || (func_i == pcg_pkg::PIN_ADC) ||
                  (func_i == pcg_pkg::PIN_ADC_PU) || (func_i == pcg_pkg::PIN_ADC_PD);
      temp_en_o <= (func_i == pcg_pkg::PIN_ADC_TEMP);
      pull_up_o <= (func_i == pcg_pkg::PIN_ADC_PU);
      pull_dn_o <= (func_i == pcg_pkg::PIN_ADC_PD);
      din_o <= (func_i == pcg_pkg::PIN_DIG_IN) ? pin_sync_i : 1'b0;
    end
  end
endmodule : pcg_pin_mux

// ---- dv/pcg_properties.sv ----
// checker for the comparator shadows of pcg_top
// assumes it is bound to pcg_top and sees its ports only
`timescale 1ns/1ps
module pcg_properties (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] voltage_cmp_mode_o,
  input wire logic [3:0] vcmp_seq_state_o,
  input wire logic [12:0] overvoltage_level_o,
  input wire logic uv_lock_threshold_select_o,
  input wire logic voltage_cmp_start_o,
  input wire logic [1:0] temp_cmp_mode_o,
  input wire logic [6:0] overtemp_level_o,
  input wire logic temp_cmp_start_o
);
  // go writes decoded once, reused below
  logic vgo;
  logic tgo;
  assign vgo = reg_wr_i && reg_addr_i == 12'h32c && reg_wdata_i[2];
  assign tgo = reg_wr_i && reg_addr_i == 12'h32d && reg_wdata_i[2];
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence vgo_s; vgo ##1 voltage_cmp_start_o; endsequence
  a_vgo_start: assert property (vgo |-> vgo_s) else $error("voltage go gave no start");
  a_vstart_cause: assert property (voltage_cmp_start_o |-> $past(vgo)) else $error("stray voltage start");
  a_tgo_start: assert property (tgo |=> temp_cmp_start_o) else $error("temp go gave no start");
  a_tstart_cause: assert property (temp_cmp_start_o |-> $past(tgo)) else $error("stray temp start");
  a_vshadow_hold: assert property ($changed(voltage_cmp_mode_o) || $changed(overvoltage_level_o)
    |-> voltage_cmp_start_o) else $error("voltage shadow moved without go");
  a_tshadow_hold: assert property ($changed(temp_cmp_mode_o) || $changed(overtemp_level_o)
    |-> temp_cmp_start_o) else $error("temp shadow moved without go");
  a_seq_one_hot: assert property (vcmp_seq_state_o == (4'h1 << voltage_cmp_mode_o))
    else $error("sequencer state off mode");
  a_lock_sel: assert property (voltage_cmp_mode_o != 2'h3 |-> !uv_lock_threshold_select_o)
    else $error("lock select outside lock");
  a_go_reads_zero: assert property (reg_rd_i && reg_addr_i == 12'h32c |=> !reg_rdata_o[2])
    else $error("go bit read as one");
endmodule : pcg_properties
bind pcg_top pcg_properties u_pcg_properties (.clock_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .voltage_cmp_mode_o, .vcmp_seq_state_o, .overvoltage_level_o,
  .uv_lock_threshold_select_o, .voltage_cmp_start_o, .temp_cmp_mode_o, .overtemp_level_o, .temp_cmp_start_o);

// ---- dv/pcg_top_tb.sv ----
// bench for pcg_top: register port calls against expected values
// assumes one-cycle strobes and read data in the following cycle
`timescale 1ns/1ps
module pcg_top_tb;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] a = 12'h000;
  logic [7:0] d = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] pin = 8'h10;
  logic [7:0] q, po, oe, adc, ten, pu, pd, din;
  logic miso, flt, usel, osel;
  logic [1:0] vm, tm;
  logic [3:0] vs, vc;
  logic [2:0] tc, utl;
  logic [15:0] uce;
  logic [12:0] ovl, uvl;
  logic [6:0] otl;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [11:0] ra [0:6] = '{12'h009, 12'h00a, 12'h00b, 12'h00c, 12'h010, 12'h32c, 12'h100};
  logic [7:0] rv [0:6] = '{8'h3f, 8'h00, 8'he0, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] oc [0:7] = '{8'h02, 8'h0e, 8'h12, 8'h1e, 8'h22, 8'h2e, 8'h0f, 8'h3f};
  int ov [0:7] = '{2700, 3000, 3500, 3800, 4175, 4475, 2700, 2700};
  always #4 clock_i = ~clock_i;
  pcg_top u_pcg_top (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(q), .pin_in_i(pin), .spi_sclk_i(1'b0), .spi_mosi_i(1'b0), .spi_cs_i(1'b0),
    .mb_drive_i(1'b0), .pin_out_o(po), .pin_oe_n_o(oe), .pin_adc_en_o(adc), .pin_temp_en_o(ten),
    .pin_pull_up_o(pu), .pin_pull_dn_o(pd), .pin_din_o(din), .spi_miso_o(miso), .fault_out_pin_o(flt),
    .voltage_cmp_mode_o(vm), .vcmp_seq_state_o(vs), .voltage_cmp_cell_o(vc), .uv_cell_enable_o(uce),
    .overvoltage_level_o(ovl), .undervoltage_level_o(uvl), .uv_lock_threshold_select_o(usel),
    .voltage_cmp_start_o(), .temp_cmp_mode_o(tm), .temp_cmp_channel_o(tc), .overtemp_level_o(otl),
    .undertemp_level_o(utl), .ot_lock_threshold_select_o(osel), .temp_cmp_start_o());
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : check
  // write, then let shadows and synced pins settle
  task automatic w(input logic [11:0] ad, input logic [7:0] dt);
    a <= ad;
    d <= dt;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : w
  // read data arrives in the cycle after the strobe and holds until the next read
  task automatic r(input logic [11:0] ad, input logic [7:0] e);
    a <= ad;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(posedge clock_i);
    check("rdata", q, e);
  endtask : r
  // hang guard, well above the few hundred cycles needed
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    foreach (ra[i]) r(ra[i], rv[i]);
    w(12'h32d, 8'hff);
    r(12'h32d, 8'h7b);
    w(12'h009, 8'h12);
    check("ov", 16'(ovl), 16'd2700);
    foreach (oc[i])
    begin
      w(12'h009, oc[i]);
      w(12'h32c, 8'h04);
      check("ov", 16'(ovl), 16'(ov[i]));
    end
    w(12'h00a, 8'h26);
    w(12'h00c, 8'h81);
    w(12'h00d, 8'h01);
    w(12'h32c, 8'h04);
    check("uv", {uce, 3'h0, uvl}, {16'h7efe, 16'd3100});
    w(12'h00b, 8'h45);
    w(12'h32d, 8'h04);
    check("ot", {6'h0, utl, otl}, {6'h0, 3'h2, 7'd15});
    for (int m = 0; m < 4; m++)
    begin
      w(12'h32c, 8'hac | 8'(m));
      w(12'h32d, 8'h74 | 8'(m));
      check("vmode", {vm, vs, vc, usel}, {2'(m), 4'h1 << m, 4'h5, m == 3});
      check("tmode", {tm, tc, osel}, {2'(m), 3'h6, m == 3});
    end
    for (int f = 0; f < 8; f++)
    begin
      w(12'h00e, 8'(f));
      check("pin1", {oe[0], po[0], adc[0], ten[0], pu[0], pd[0]},
        {f != 4 && f != 5, f == 4, f == 1 || f == 2 || f > 5, f == 1, f == 6, f == 7});
    end
    w(12'h010, 8'h03);
    check("din5", {din[4], din[0]}, 2'b10);
    w(12'h011, 8'h24);
    w(12'h00e, 8'hc0);
    check("spi", {po[6], miso, flt}, 3'b010);
    w(12'h00e, 8'h00);
    check("gpio", {po[6], miso, flt}, 3'b101);
    w(12'h00f, 8'h04);
    check("pin3", po[2], 1'b1);
    w(12'h329, 8'h01);
    check("pin3", po[2], 1'b0);
    conclude();
  end
endmodule : pcg_top_tb
